// ---- src/frs_pkg.sv ----
// Behaviour
// - Ones digit 0 selects main channel X alone.
// - Ones digit 1 selects the main/auxiliary arithmetic result.
// - Ones digit 2: X while switch input low, Y while high.
// - Ones digit 3: X while switch low, arithmetic result while high.
// - Ones digit 4: Y while switch low, arithmetic result while high.
// - Tens digit 0: arithmetic result is X plus Y.
// - Tens digit 1: arithmetic result is X minus Y.
// - Tens digit 2: arithmetic result is the one with larger magnitude.
// - Tens digit 3: arithmetic result is the one with smaller magnitude.
// - Offset frequency is added whenever the arithmetic result is used.
// - Digital mode starts from the digital frequency, default 50.00 Hz.
// - Run direction setting reverses the output rotation.
// - Full-scale analog input equals the maximum frequency.
// - Decimal select 1: 0.1 Hz, 50.0-3200.0; select 2: 0.01 Hz, 50.00-500.00.
// - Upper limit from digital value or analog; 100 percent equals digital value.
// - Digital upper limit held between lower limit and maximum, default 50.00 Hz.
// - Below lower limit: stop, run at lower limit, or zero speed.
// - Carrier setting accepted from 0.5 kHz to 16.0 kHz.
// - Derating lowers carrier while hot, restores gradually when cool.
// - Ramp up time spans zero to reference frequency.
// - Ramp down time spans reference frequency to zero.
// - Ramp times count in 1 s, 0.1 s or 0.01 s units, default 0.1 s.
package frs_pkg;
    localparam int          FW               = 18;
    localparam int          CLK_HZ           = 25_000_000;
    localparam int          TICK_HZ          = 100;
    localparam int          TICK_CYCLES      = CLK_HZ / TICK_HZ;
    localparam logic [17:0] DIGITAL_DEF      = 18'h01388;
    localparam logic [17:0] UPPER_DEF        = 18'h01388;
    localparam logic [17:0] LOWER_DEF        = 18'h00000;
    localparam logic [17:0] MAX_DEF          = 18'h01388;
    localparam logic [17:0] MAX_MIN_D1       = 18'h001F4;
    localparam logic [17:0] MAX_MAX_D1       = 18'h07D00;
    localparam logic [17:0] MAX_MIN_D2       = 18'h01388;
    localparam logic [17:0] MAX_MAX_D2       = 18'h0C350;
    localparam logic [15:0] ANALOG_FULL      = 16'h03E8;
    localparam logic [7:0]  CARRIER_MIN      = 8'h05;
    localparam logic [7:0]  CARRIER_MAX      = 8'hA0;
    localparam logic [7:0]  CARRIER_HOT_STEP = 8'h01;
    localparam int          CARRIER_RECOVER  = 100;
    localparam logic [1:0]  UNIT_DEF         = 2'h1;
    localparam logic [3:0]  ONES_X           = 4'h0;
    localparam logic [3:0]  ONES_XY          = 4'h1;
    localparam logic [3:0]  ONES_X_Y         = 4'h2;
    localparam logic [3:0]  ONES_X_XY        = 4'h3;
    localparam logic [3:0]  ONES_Y_XY        = 4'h4;
    localparam logic [3:0]  TENS_SUM         = 4'h0;
    localparam logic [3:0]  TENS_DIFF        = 4'h1;
    localparam logic [3:0]  TENS_MAX         = 4'h2;
    localparam logic [3:0]  TENS_MIN         = 4'h3;
    localparam logic [1:0]  LOW_STOP         = 2'h0;
    localparam logic [1:0]  LOW_RUN_LOWER    = 2'h1;
    localparam logic [1:0]  LOW_ZERO         = 2'h2;

    typedef struct packed {
        logic [7:0]  channel_combination_select;
        logic [1:0]  frequency_decimal_select;
        logic [17:0] maximum_frequency_setting;
        logic [17:0] upper_limit_frequency;
        logic [17:0] lower_limit_frequency;
        logic [17:0] combination_offset_frequency;
        logic        upper_limit_source_select;
        logic [1:0]  below_lower_limit_action;
    } frs_cfg_type;

    typedef enum logic [1:0] {
        RS_IDLE = 2'b00,
        RS_UP   = 2'b01,
        RS_HOLD = 2'b11,
        RS_DOWN = 2'b10
    } frs_ramp_type;

    function automatic logic signed [17:0] frs_abs(input logic signed [17:0] v);
        return v[17] ? -v : v;
    endfunction

    function automatic logic signed [17:0] frs_sat(input logic signed [18:0] v);
        if (v > 19'sh1FFFF) return 18'sh1FFFF;
        if (v < -19'sh1FFFF) return -18'sh1FFFF;
        return v[17:0];
    endfunction
endpackage

// ---- src/frs_carrier.sv ----
`timescale 1ns/1ps
module frs_carrier
    import frs_pkg::*;
(
    input  wire logic       clock,
    input  wire logic       rstn,
    input  wire logic       tick,
    input  wire logic [7:0] carrier_frequency_setting,
    input  wire logic       carrier_thermal_derate_enable,
    input  wire logic       heatsink_hot,
    output logic      [7:0] carrier_q
);
    logic [7:0] set_clamped;
    logic [7:0] recover_q;
    logic [7:0] carrier_d;
    logic       recover_tick;

    // Out-of-range settings are held at the nearest limit
    assign set_clamped = (carrier_frequency_setting < CARRIER_MIN) ? CARRIER_MIN :
                         (carrier_frequency_setting > CARRIER_MAX) ? CARRIER_MAX :
                         carrier_frequency_setting;
    assign recover_tick = tick && (recover_q == 8'(CARRIER_RECOVER - 1));

    always_comb begin
        carrier_d = carrier_q;
        if (!carrier_thermal_derate_enable) begin
            carrier_d = set_clamped;
        end else if (heatsink_hot) begin
            if (tick && carrier_q > CARRIER_MIN) begin
                carrier_d = carrier_q - CARRIER_HOT_STEP;
            end
        end else if (recover_tick && carrier_q < set_clamped) begin
            carrier_d = carrier_q + CARRIER_HOT_STEP;
        end else if (carrier_q > set_clamped) begin
            carrier_d = set_clamped;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            carrier_q <= CARRIER_MIN;
            recover_q <= 8'h00;
        end else begin
            carrier_q <= carrier_d;
            if (tick) begin
                recover_q <= recover_tick ? 8'h00 : recover_q + 8'h01;
            end
        end
    end
endmodule // frs_carrier

// ---- src/frs_ramp.sv ----
`timescale 1ns/1ps
module frs_ramp
    import frs_pkg::*;
(
    input  wire logic               clock,
    input  wire logic               rstn,
    input  wire logic               tick,
    input  wire logic               run,
    input  wire logic signed [17:0] target,
    input  wire logic        [17:0] ref_freq,
    input  wire logic        [15:0] ramp_up_time,
    input  wire logic        [15:0] ramp_down_time,
    input  wire logic        [1:0]  ramp_time_unit_select,
    output logic signed      [17:0] out_q,
    output frs_ramp_type            state_q
);
    logic        [31:0] acc_q;
    logic        [31:0] unit_ticks;
    logic        [31:0] span;
    logic        [31:0] acc_d;
    logic               step;
    logic signed [17:0] goal;
    logic signed [17:0] out_d;
    frs_ramp_type       state_d;

    assign goal = run ? target : 18'sh0;
    // Ticks per time unit at a 100 Hz base
    assign unit_ticks = (ramp_time_unit_select == 2'h0) ? 32'h64 :
                        (ramp_time_unit_select == 2'h1) ? 32'h0A : 32'h01;
    assign span = unit_ticks * 32'((goal > out_q) ? ramp_up_time : ramp_down_time);
    // Accumulate ref per tick; step by one LSB per span-worth of accumulation
    assign acc_d = acc_q + {14'h0, ref_freq};
    assign step  = tick && (span == 32'h0 || acc_d >= span);

    always_comb begin
        out_d   = out_q;
        state_d = RS_HOLD;
        if (goal > out_q) begin
            state_d = RS_UP;
            if (span == 32'h0) out_d = goal;
            else if (step) out_d = out_q + 18'sh1;
        end else if (goal < out_q) begin
            state_d = RS_DOWN;
            if (span == 32'h0) out_d = goal;
            else if (step) out_d = out_q - 18'sh1;
        end else if (!run) begin
            state_d = RS_IDLE;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            out_q   <= 18'sh0;
            acc_q   <= 32'h0;
            state_q <= RS_IDLE;
        end else begin
            out_q   <= out_d;
            state_q <= state_d;
            if (tick) acc_q <= (step && span != 32'h0) ? acc_d - span : acc_d;
        end
    end
endmodule // frs_ramp

// ---- src/frs_top.sv ----
`timescale 1ns/1ps
module frs_top
    import frs_pkg::*;
(
    input  wire logic               clock,
    input  wire logic               rstn,
    input  wire frs_cfg_type        cfg,
    input  wire logic signed [17:0] channel_x,
    input  wire logic signed [17:0] channel_y,
    input  wire logic               digital_mode,
    input  wire logic               digital_load,
    input  wire logic        [17:0] digital_frequency_initial,
    input  wire logic               frequency_switch,
    input  wire logic               x_is_analog,
    input  wire logic        [15:0] analog_x_permille,
    input  wire logic        [15:0] analog_limit_permille,
    input  wire logic               rotation_reverse_select,
    input  wire logic               run_request,
    input  wire logic        [7:0]  carrier_frequency_setting,
    input  wire logic               carrier_thermal_derate_enable,
    input  wire logic               heatsink_hot,
    input  wire logic        [15:0] ramp_up_time,
    input  wire logic        [15:0] ramp_down_time,
    input  wire logic        [1:0]  ramp_time_unit_select,
    input  wire logic               ramp_reference_frequency_select,
    output logic signed      [17:0] target_q,
    output logic signed      [17:0] output_frequency_q,
    output logic                    reverse_q,
    output logic                    running_q,
    output logic             [17:0] upper_limit_q,
    output logic             [7:0]  carrier_q
);
    logic [3:0]         ones;
    logic [3:0]         tens;
    logic [17:0]        max_freq;
    logic [17:0]        dig_upper;
    logic [17:0]        ana_upper;
    logic [17:0]        eff_upper;
    logic signed [17:0] x_eff;
    logic signed [17:0] arith;
    logic signed [17:0] arith_off;
    logic               use_arith;
    logic               use_y;
    logic signed [17:0] combined;
    logic signed [17:0] clamped;
    logic [17:0]        mag;
    logic               below;
    logic signed [17:0] limited;
    logic               run_eff;
    logic [17:0]        digital_q;
    logic [17:0]        ramp_ref;
    logic [31:0]        tick_cnt_q;
    logic               tick_q;
    logic signed [17:0] ramp_out;
    logic [7:0]         carrier_w;
    frs_ramp_type       ramp_state;

    assign ones = cfg.channel_combination_select[3:0];
    assign tens = cfg.channel_combination_select[7:4];

    // Maximum frequency held inside the range of the chosen resolution
    assign max_freq = (cfg.frequency_decimal_select == 2'h1) ?
        ((cfg.maximum_frequency_setting < MAX_MIN_D1) ? MAX_MIN_D1 :
         (cfg.maximum_frequency_setting > MAX_MAX_D1) ? MAX_MAX_D1 :
          cfg.maximum_frequency_setting) :
        ((cfg.maximum_frequency_setting < MAX_MIN_D2) ? MAX_MIN_D2 :
         (cfg.maximum_frequency_setting > MAX_MAX_D2) ? MAX_MAX_D2 :
          cfg.maximum_frequency_setting);

    assign dig_upper = (cfg.upper_limit_frequency > max_freq) ? max_freq :
                       (cfg.upper_limit_frequency < cfg.lower_limit_frequency) ?
                        cfg.lower_limit_frequency : cfg.upper_limit_frequency;
    assign ana_upper = 18'(({14'h0, dig_upper} * {16'h0, analog_limit_permille})
                           / {16'h0, ANALOG_FULL});
    assign eff_upper = cfg.upper_limit_source_select ? ana_upper : dig_upper;

    assign x_eff = digital_mode ? $signed(digital_q) :
                   x_is_analog ? $signed(18'(({14'h0, max_freq} *
                       {16'h0, analog_x_permille}) / {16'h0, ANALOG_FULL})) :
                   channel_x;

    assign arith = (tens == TENS_SUM)  ? frs_sat(19'(x_eff) + 19'(channel_y)) :
                   (tens == TENS_DIFF) ? frs_sat(19'(x_eff) - 19'(channel_y)) :
                   (tens == TENS_MAX)  ? ((frs_abs(x_eff) >= frs_abs(channel_y)) ?
                                          x_eff : channel_y) :
                   ((frs_abs(x_eff) <= frs_abs(channel_y)) ? x_eff : channel_y);
    assign arith_off = frs_sat(19'(arith) +
                       19'($signed({1'b0, cfg.combination_offset_frequency})));

    assign use_arith = (ones == ONES_XY) ||
                       (frequency_switch && (ones == ONES_X_XY || ones == ONES_Y_XY));
    assign use_y     = (ones == ONES_X_Y && frequency_switch) ||
                       (ones == ONES_Y_XY && !frequency_switch);
    assign combined  = use_arith ? arith_off : use_y ? channel_y : x_eff;

    assign mag     = 18'(frs_abs(combined));
    assign clamped = (mag > eff_upper) ? (combined[17] ? -$signed(eff_upper)
                                                        : $signed(eff_upper)) :
                     combined;
    assign below   = mag < cfg.lower_limit_frequency;
    assign limited = !below ? clamped :
                     (cfg.below_lower_limit_action == LOW_RUN_LOWER) ?
                        $signed(cfg.lower_limit_frequency) : 18'sh0;
    assign run_eff = run_request && !(below && cfg.below_lower_limit_action == LOW_STOP);

    assign ramp_ref = ramp_reference_frequency_select ? mag : max_freq;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            digital_q <= DIGITAL_DEF;
        end else if (digital_load) begin
            digital_q <= digital_frequency_initial;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            tick_cnt_q <= 32'h0;
            tick_q     <= 1'b0;
        end else begin
            tick_q     <= (tick_cnt_q == 32'(TICK_CYCLES - 1));
            tick_cnt_q <= (tick_cnt_q == 32'(TICK_CYCLES - 1)) ? 32'h0 : tick_cnt_q + 32'h1;
        end
    end

    frs_ramp u_ramp (
        .clock                 (clock),
        .rstn                  (rstn),
        .tick                  (tick_q),
        .run                   (run_eff),
        .target                (limited),
        .ref_freq              (ramp_ref),
        .ramp_up_time          (ramp_up_time),
        .ramp_down_time        (ramp_down_time),
        .ramp_time_unit_select (ramp_time_unit_select),
        .out_q                 (ramp_out),
        .state_q               (ramp_state)
    );

    frs_carrier u_carrier (
        .clock                         (clock),
        .rstn                          (rstn),
        .tick                          (tick_q),
        .carrier_frequency_setting     (carrier_frequency_setting),
        .carrier_thermal_derate_enable (carrier_thermal_derate_enable),
        .heatsink_hot                  (heatsink_hot),
        .carrier_q                     (carrier_w)
    );

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            target_q           <= 18'sh0;
            output_frequency_q <= 18'sh0;
            reverse_q          <= 1'b0;
            running_q          <= 1'b0;
            upper_limit_q      <= UPPER_DEF;
            carrier_q          <= CARRIER_MIN;
        end else begin
            target_q           <= limited;
            output_frequency_q <= ramp_out;
            reverse_q          <= rotation_reverse_select ^ ramp_out[17];
            running_q          <= ramp_state != RS_IDLE;
            upper_limit_q      <= eff_upper;
            carrier_q          <= carrier_w;
        end
    end

    property p_mode_x;
        @(posedge clock) disable iff (!rstn)
        (ones == ONES_X && !digital_mode && !x_is_analog && mag <= eff_upper
         && !below) |=> target_q == $past(channel_x);
    endproperty
    a_mode_x: assert property (p_mode_x) else $error("x not selected");

    property p_switch_y;
        @(posedge clock) disable iff (!rstn)
        (ones == ONES_X_Y && frequency_switch && !below && mag <= eff_upper)
        |=> target_q == $past(channel_y);
    endproperty
    a_switch_y: assert property (p_switch_y) else $error("y not selected");

    property p_sum;
        @(posedge clock) disable iff (!rstn)
        (ones == ONES_XY && tens == TENS_SUM && !below && mag <= eff_upper
         && x_eff[17:16] == 2'h0 && channel_y[17:16] == 2'h0)
        |=> target_q == 18'($past(x_eff) + $past(channel_y)
                             + $past(cfg.combination_offset_frequency));
    endproperty
    a_sum: assert property (p_sum) else $error("sum wrong");

    property p_clamp;
        @(posedge clock) disable iff (!rstn)
        ##1 (18'(frs_abs(target_q)) <= $past(eff_upper) ||
             $past(below && cfg.below_lower_limit_action == LOW_RUN_LOWER));
    endproperty
    a_clamp: assert property (p_clamp) else $error("target above limit");

    property p_low_stop;
        @(posedge clock) disable iff (!rstn)
        (below && cfg.below_lower_limit_action != LOW_RUN_LOWER) |=> target_q == 18'sh0;
    endproperty
    a_low_stop: assert property (p_low_stop) else $error("below limit not zero");

    property p_upper_bound;
        @(posedge clock) disable iff (!rstn)
        !cfg.upper_limit_source_select |=> upper_limit_q <= max_freq[17:0] + 18'h0
            || $changed(cfg);
    endproperty
    a_upper_bound: assert property (p_upper_bound) else $error("upper above max");

    property p_carrier_range;
        @(posedge clock) disable iff (!rstn)
        ##2 (carrier_q >= CARRIER_MIN && carrier_q <= CARRIER_MAX);
    endproperty
    a_carrier_range: assert property (p_carrier_range) else $error("carrier range");

    property p_ramp_step;
        @(posedge clock) disable iff (!rstn)
        (ramp_up_time != 16'h0 && $past(ramp_up_time) != 16'h0 &&
         ramp_down_time != 16'h0 && $past(ramp_down_time) != 16'h0 && !tick_q)
        |=> output_frequency_q == $past(output_frequency_q, 1) || $past(tick_q, 2);
    endproperty
    a_ramp_step: assert property (p_ramp_step) else $error("ramp moved off tick");

    property p_reverse;
        @(posedge clock) disable iff (!rstn)
        1'b1 |=> reverse_q == ($past(rotation_reverse_select) ^ output_frequency_q[17]);
    endproperty
    a_reverse: assert property (p_reverse) else $error("direction wrong");
endmodule // frs_top

// ---- tb/frs_terminal_model.sv ----
`timescale 1ns/1ps
module frs_terminal_model
    import frs_pkg::*;
(
    input  wire logic clock,
    input  wire logic rstn,
    input  wire logic sw_cmd,
    input  wire logic hot_cmd,
    output logic      frequency_switch,
    output logic      heatsink_hot
);
    // Terminal filter and heatsink sensor, one register deep
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            frequency_switch <= 1'b0;
            heatsink_hot     <= 1'b0;
        end else begin
            frequency_switch <= sw_cmd;
            heatsink_hot     <= hot_cmd;
        end
    end
endmodule // frs_terminal_model

// ---- tb/test_frequency_reference_selector.sv ----
`timescale 1ns/1ps
`define CHK(w, e, g) chk(w, 18'(e), 18'(g))
module test_frequency_reference_selector;
    import frs_pkg::*;
    logic clock, rstn, digital_mode, digital_load, x_is_analog, rotation_reverse_select;
    logic run_request, carrier_thermal_derate_enable, ramp_reference_frequency_select;
    logic sw_cmd, hot_cmd, frequency_switch, heatsink_hot, reverse_q, running_q;
    frs_cfg_type        cfg;
    logic signed [17:0] channel_x, channel_y, target_q, output_frequency_q;
    logic        [17:0] digital_frequency_initial, upper_limit_q;
    logic        [15:0] analog_x_permille, analog_limit_permille, ramp_up_time, ramp_down_time;
    logic        [7:0]  carrier_frequency_setting, carrier_q;
    logic        [1:0]  ramp_time_unit_select;
    int                 num_errors, n_compared, x, y, off, on, tn, sw, k;
    int                 mx [3] = '{100, 50000, 60000};
    int                 dsel [3] = '{1, 1, 2};
    int                 lim [3] = '{500, 32000, 50000};

    frs_top frs_top_i (.clock(clock), .rstn(rstn), .cfg(cfg), .channel_x(channel_x),
        .channel_y(channel_y), .digital_mode(digital_mode), .digital_load(digital_load),
        .digital_frequency_initial(digital_frequency_initial),
        .frequency_switch(frequency_switch), .x_is_analog(x_is_analog),
        .analog_x_permille(analog_x_permille), .analog_limit_permille(analog_limit_permille),
        .rotation_reverse_select(rotation_reverse_select), .run_request(run_request),
        .carrier_frequency_setting(carrier_frequency_setting),
        .carrier_thermal_derate_enable(carrier_thermal_derate_enable),
        .heatsink_hot(heatsink_hot), .ramp_up_time(ramp_up_time),
        .ramp_down_time(ramp_down_time), .ramp_time_unit_select(ramp_time_unit_select),
        .ramp_reference_frequency_select(ramp_reference_frequency_select),
        .target_q(target_q), .output_frequency_q(output_frequency_q), .reverse_q(reverse_q),
        .running_q(running_q), .upper_limit_q(upper_limit_q), .carrier_q(carrier_q));

    frs_terminal_model frs_terminal_model_i (.clock(clock), .rstn(rstn), .sw_cmd(sw_cmd),
        .hot_cmd(hot_cmd), .frequency_switch(frequency_switch), .heatsink_hot(heatsink_hot));

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    task automatic chk(input string w, input logic [17:0] e, input logic [17:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s expected %0d seen %0d", w, e, g);
        end
    endtask

    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic settle();
        repeat (4) @(posedge clock);
        @(negedge clock);
    endtask

    // Bounded wait for the ramp output to reach a value
    task automatic wait_out(input int goal);
        for (int i = 0; i < 60 && output_frequency_q !== 18'(goal); i++)
            @(negedge clock);
    endtask

    function automatic int exp_target(int o, int t, int s, int a, int b, int f, int l);
        int ar, r;
        ar = (t == 0) ? a + b : (t == 1) ? a - b : (t == 2) ? ((a > b) ? a : b)
                                                            : ((a < b) ? a : b);
        r = (o == 0) ? a : (o == 1) ? ar + f : (o == 2) ? (s ? b : a)
          : (o == 3) ? (s ? ar + f : a) : (s ? ar + f : b);
        return (r > l) ? l : r;
    endfunction

    initial begin
        #(40ns * 5000);
        num_errors++;
        end_of_test();
    end

    initial begin
        rstn = 1'b0;
        cfg = '{8'h00, 2'h2, MAX_DEF, UPPER_DEF, LOWER_DEF, 18'h00000, 1'b0, LOW_RUN_LOWER};
        {digital_mode, digital_load, x_is_analog, rotation_reverse_select} = 4'h0;
        {run_request, carrier_thermal_derate_enable, ramp_reference_frequency_select} = 3'h0;
        {sw_cmd, hot_cmd} = 2'h0;
        channel_x = 18'sh003E8;
        channel_y = 18'sh00000;
        digital_frequency_initial = 18'h004D2;
        analog_x_permille = 16'h0000;
        analog_limit_permille = ANALOG_FULL;
        {ramp_up_time, ramp_down_time} = 32'h0;
        carrier_frequency_setting = 8'h50;
        ramp_time_unit_select = UNIT_DEF;
        repeat (8) @(posedge clock);
        rstn <= 1'b1;
        void'($urandom(32'h01C1DB0A));
        settle();
        `CHK("upper_limit_q", 5000, upper_limit_q);
        `CHK("carrier_q", 80, carrier_q);
        @(posedge clock);
        digital_mode <= 1'b1;
        settle();
        `CHK("target_q digital default", 5000, target_q);
        @(posedge clock);
        digital_load <= 1'b1;
        @(posedge clock);
        digital_load <= 1'b0;
        settle();
        `CHK("target_q digital load", 1234, target_q);
        @(posedge clock);
        digital_mode <= 1'b0;
        $display("test reset and digital done");
        for (k = 0; k < 61; k++) begin
            on = (k < 40) ? k % 5 : $urandom_range(4);
            tn = (k < 40) ? (k / 5) % 4 : $urandom_range(3);
            sw = (k < 40) ? (k / 20) : $urandom_range(1);
            x = (k == 60) ? 3000 : $urandom_range(2000);
            y = (k == 60) ? 3000 : $urandom_range(2000);
            off = $urandom_range(500);
            if (tn == 1 && y > x) y = x;
            @(posedge clock);
            cfg.channel_combination_select <= {4'(tn), 4'(on)};
            cfg.combination_offset_frequency <= 18'(off);
            channel_x <= 18'(x);
            channel_y <= 18'(y);
            sw_cmd <= sw[0];
            settle();
            `CHK("target_q", exp_target(on, tn, sw, x, y, off, 5000), target_q);
        end
        $display("test combination done");
        @(posedge clock);
        cfg.channel_combination_select <= 8'h00;
        channel_x <= 18'sh01000;
        rotation_reverse_select <= 1'b1;
        settle();
        `CHK("reverse_q", 1, reverse_q);
        @(posedge clock);
        rotation_reverse_select <= 1'b0;
        x_is_analog <= 1'b1;
        analog_x_permille <= 16'h00FA;
        settle();
        `CHK("reverse_q", 0, reverse_q);
        `CHK("target_q analog", 1250, target_q);
        @(posedge clock);
        analog_x_permille <= ANALOG_FULL;
        cfg.upper_limit_source_select <= 1'b1;
        analog_limit_permille <= 16'h01F4;
        settle();
        `CHK("upper_limit_q analog", 2500, upper_limit_q);
        `CHK("target_q clamped", 2500, target_q);
        $display("test analog done");
        for (k = 0; k < 3; k++) begin
            @(posedge clock);
            cfg.frequency_decimal_select <= 2'(dsel[k]);
            cfg.maximum_frequency_setting <= 18'(mx[k]);
            cfg.upper_limit_frequency <= 18'h3FFFF;
            cfg.upper_limit_source_select <= 1'b0;
            settle();
            `CHK("upper_limit_q held", lim[k], upper_limit_q);
        end
        @(posedge clock);
        cfg.lower_limit_frequency <= 18'h003E8;
        cfg.below_lower_limit_action <= LOW_STOP;
        channel_x <= 18'sh001F4;
        x_is_analog <= 1'b0;
        settle();
        `CHK("target_q below stop", 0, target_q);
        @(posedge clock);
        cfg.below_lower_limit_action <= LOW_RUN_LOWER;
        settle();
        `CHK("target_q below lower", 1000, target_q);
        @(posedge clock);
        cfg.below_lower_limit_action <= LOW_ZERO;
        settle();
        `CHK("target_q below zero", 0, target_q);
        $display("test lower limit done");
        @(posedge clock);
        cfg <= '{8'h00, 2'h2, MAX_DEF, UPPER_DEF, LOWER_DEF, 18'h00000, 1'b0, LOW_RUN_LOWER};
        x_is_analog <= 1'b0;
        channel_x <= 18'sh00BB8;
        carrier_frequency_setting <= 8'hC8;
        run_request <= 1'b1;
        settle();
        `CHK("carrier_q high", 160, carrier_q);
        wait_out(3000);
        `CHK("output_frequency_q up", 3000, output_frequency_q);
        `CHK("running_q", 1, running_q);
        @(posedge clock);
        run_request <= 1'b0;
        carrier_frequency_setting <= 8'h03;
        settle();
        `CHK("carrier_q low", 5, carrier_q);
        @(posedge clock);
        carrier_thermal_derate_enable <= 1'b1;
        carrier_frequency_setting <= 8'hA0;
        hot_cmd <= 1'b1;
        settle();
        `CHK("carrier_q derated", 5, carrier_q);
        @(posedge clock);
        hot_cmd <= 1'b0;
        settle();
        `CHK("carrier_q recovering", 5, carrier_q);
        wait_out(0);
        @(negedge clock);
        `CHK("output_frequency_q down", 0, output_frequency_q);
        `CHK("running_q", 0, running_q);
        @(posedge clock);
        {ramp_up_time, ramp_down_time} <= {16'h0001, 16'h0001};
        run_request <= 1'b1;
        settle();
        `CHK("output_frequency_q held", 0, output_frequency_q);
        `CHK("running_q ramping", 1, running_q);
        $display("test ramp and carrier done");
        end_of_test();
    end
endmodule // test_frequency_reference_selector
